//--- rtl/aio_pkg.sv
// Shared constants for the analog I/O channel control block.
// Assumes a 50 MHz system clock and a 16-bit host register port.
package aio_pkg;

  // ----------------------------------------------------------------
  // Channel and word geometry
  // ----------------------------------------------------------------
  localparam int CHANNELS = 16;  // Analog output and input channel count.
  localparam int SEL_W = 4;  // Width of the input channel select field.
  localparam int CODE_W = 12;  // Converter code width, right-justified.
  localparam int WORD_W = 16;  // Host data word width.
  localparam int ADDR_W = 8;  // Host byte address width.

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, 16-bit words)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h02;  // Control word.
  localparam logic [ADDR_W-1:0] OFF_CONV_DATA = 8'h04;  // Converter data word.
  localparam logic [ADDR_W-1:0] OFF_OUT_BASE = 8'h20;  // First output channel code.
  localparam logic [ADDR_W-1:0] OFF_OUT_END = 8'h40;  // One past the last output word.

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int CTRL_SEL_LSB = 0;  // Input select occupies bits 3..0.
  localparam int CTRL_ONLINE_BIT = 11;  // Outputs connected to the rear connector.
  localparam int CTRL_FAST_BIT = 12;  // Fast refresh period.
  localparam logic [WORD_W-1:0] CTRL_RESET = 16'h0000;  // Offline, slow, channel 0.
  localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;  // Output code after reset.

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_PERIOD_NS = 20;  // System clock period.
  localparam longint REFRESH_SLOW_NS = 1_700_000;  // Default full refresh period, 1.7 ms.
  localparam longint REFRESH_FAST_NS = 400_000;  // Fast full refresh period, 0.4 ms.
  // Slot times round down so a full sweep never exceeds the period.
  localparam int SLOW_SLOT_CYC = int'(REFRESH_SLOW_NS / CLK_PERIOD_NS / CHANNELS);
  localparam int FAST_SLOT_CYC = int'(REFRESH_FAST_NS / CLK_PERIOD_NS / CHANNELS);
  localparam int SLOT_CNT_W = 16;  // Holds either slot count.

endpackage

//--- rtl/aio_slot_timer.sv
// Refresh slot timer: emits a one-cycle tick at the end of each channel slot.
// Assumes the slot lengths are at least two cycles and fit the counter width.
`timescale 1ns/1ps
module aio_slot_timer #(
  parameter int CNT_W = 16,
  parameter logic [15:0] SLOW_CYC = 16'h14c0,
  parameter logic [15:0] FAST_CYC = 16'h04e2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fast,
  output logic tick
);

  // ----------------------------------------------------------------
  // Slot counter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt;  // Cycles elapsed in the current slot.
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] limit;  // Last count of the slot for the chosen speed.

  // The period is picked live, so a speed change takes effect in the current slot.
  // Using >= means a switch from slow to fast never strands the counter past the end.
  always_comb begin
    limit = fast ? CNT_W'(FAST_CYC - 16'h0001) : CNT_W'(SLOW_CYC - 16'h0001);
    tick = (cnt >= limit);
    next_cnt = tick ? '0 : CNT_W'(cnt + 1'b1);
  end

  // Register the count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule

//--- rtl/aio_chan_decode.sv
// Channel decoder: turns a binary channel number into a one-hot vector.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module aio_chan_decode #(
  parameter int SEL_W = 4
) (
  input wire logic [SEL_W-1:0] sel,
  output logic [(1<<SEL_W)-1:0] onehot
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // The code is the channel number itself: code 0 is channel 00, all ones the last.
  function automatic logic [(1<<SEL_W)-1:0] to_onehot(input logic [SEL_W-1:0] s);
    logic [(1<<SEL_W)-1:0] v;
    v = '0;
    v[s] = 1'b1;
    return v;
  endfunction

  // Exactly one channel line is raised for every code.
  always_comb begin
    onehot = to_onehot(sel);
  end

endmodule

//--- rtl/aio_chan_ctrl.sv
// Channel-side control of a 16-channel analog I/O board: control word,
// output code registers, round-robin converter refresh and output online switch.
// Assumes a host port synchronous to CLK_SYS with one-cycle read and write strobes.
`timescale 1ns/1ps

module aio_chan_ctrl
  import aio_pkg::*;
#(
  parameter int SLOW_SLOT = aio_pkg::SLOW_SLOT_CYC,
  parameter int FAST_SLOT = aio_pkg::FAST_SLOT_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [aio_pkg::ADDR_W-1:0] ADDR,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [aio_pkg::WORD_W-1:0] WDATA,
  output logic [aio_pkg::WORD_W-1:0] RDATA,
  output logic RD_ACK,
  output logic [aio_pkg::SEL_W-1:0] IN_CHAN_SEL,
  output logic [aio_pkg::CHANNELS-1:0] IN_CHAN_ONEHOT,
  output logic [aio_pkg::CODE_W-1:0] DAC_CODE,
  output logic [aio_pkg::SEL_W-1:0] DAC_CHAN,
  output logic DAC_LOAD,
  output logic FAST_REFRESH,
  output logic REAR_IO_CONNECT,
  output logic SELFTEST_TAP_EN
);
  import aio_pkg::*;

  // ----------------------------------------------------------------
  // Address decoding helpers
  // ----------------------------------------------------------------
  // True for an even byte address inside the output code window.
  function automatic logic is_out_addr(input logic [ADDR_W-1:0] a);
    return (a >= OFF_OUT_BASE) && (a < OFF_OUT_END) && !a[0];
  endfunction

  // Channel number of an output code word, one word per channel.
  function automatic logic [SEL_W-1:0] out_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = ADDR_W'(a - OFF_OUT_BASE);
    return d[SEL_W:1];
  endfunction

  // ----------------------------------------------------------------
  // Control word
  // ----------------------------------------------------------------
  logic [SEL_W-1:0] sel;  // Input channel select.
  logic [SEL_W-1:0] next_sel;
  logic fast;  // Fast refresh selected.
  logic next_fast;
  logic online;  // Outputs connected to the rear connector.
  logic next_online;
  logic [CHANNELS-1:0] sel_onehot;  // Decoded next select.
  logic ctrl_wr;  // Host writes the control word this cycle.

  // Only bits 3..0 of the word reach the select; bits 11 and 12 go to their own fields.
  always_comb begin
    ctrl_wr = WR_STB && (ADDR == OFF_CTRL);
    next_sel = sel;
    next_fast = fast;
    next_online = online;
    if (ctrl_wr) begin
      next_sel = WDATA[CTRL_SEL_LSB +: SEL_W];
      next_fast = WDATA[CTRL_FAST_BIT];
      next_online = WDATA[CTRL_ONLINE_BIT];
    end
  end

  // Decode the select straight to a channel line.
  aio_chan_decode #(
    .SEL_W(SEL_W)
  ) u_decode (
    .sel(next_sel),
    .onehot(sel_onehot)
  );

  // Register the control fields; outputs mirror them directly.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sel <= CTRL_RESET[CTRL_SEL_LSB +: SEL_W];
      fast <= CTRL_RESET[CTRL_FAST_BIT];
      online <= CTRL_RESET[CTRL_ONLINE_BIT];
      IN_CHAN_ONEHOT <= CHANNELS'(1);
    end else begin
      sel <= next_sel;
      fast <= next_fast;
      online <= next_online;
      IN_CHAN_ONEHOT <= sel_onehot;
    end
  end

  assign IN_CHAN_SEL = sel;
  assign FAST_REFRESH = fast;
  // The rear connector switch follows the online bit alone.
  assign REAR_IO_CONNECT = online;
  // Buffers stay tapped for the self-test path whatever the online state,
  // so loopback checks work with the connector isolated.
  assign SELFTEST_TAP_EN = 1'b1;

  // ----------------------------------------------------------------
  // Output code registers
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] out_code [CHANNELS];  // One stored code per output.
  logic [CODE_W-1:0] next_out_code [CHANNELS];

  // A write keeps only the low twelve bits; bits 15..12 are never stored.
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      next_out_code[i] = out_code[i];
    end
    if (WR_STB && is_out_addr(ADDR)) begin
      next_out_code[out_index(ADDR)] = WDATA[CODE_W-1:0];
    end
  end

  // Register the code array.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < CHANNELS; i++) begin
        out_code[i] <= CODE_RESET;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        out_code[i] <= next_out_code[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Host read port
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] next_rdata;

  // Reads answer one cycle later; unmapped addresses read as zero.
  always_comb begin
    next_rdata = '0;
    if (!RD_STB) begin
      next_rdata = '0;
    end else if (ADDR == OFF_CTRL) begin
      next_rdata[CTRL_SEL_LSB +: SEL_W] = sel;
      next_rdata[CTRL_FAST_BIT] = fast;
      next_rdata[CTRL_ONLINE_BIT] = online;
    end else if (ADDR == OFF_CONV_DATA) begin
      next_rdata = WORD_W'(DAC_CODE);
    end else if (is_out_addr(ADDR)) begin
      next_rdata = WORD_W'(out_code[out_index(ADDR)]);
    end
  end

  // Register read data and acknowledge.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= '0;
      RD_ACK <= 1'b0;
    end else begin
      RDATA <= next_rdata;
      RD_ACK <= RD_STB;
    end
  end

  // ----------------------------------------------------------------
  // Refresh sequencer
  // ----------------------------------------------------------------
  logic slot_tick;  // End of one channel slot.
  logic [SEL_W-1:0] scan;  // Channel refreshed at the next tick.
  logic [SEL_W-1:0] next_scan;
  logic [CODE_W-1:0] next_dac_code;
  logic [SEL_W-1:0] next_dac_chan;

  // Sixteen slots make one sweep, so a sweep fits inside the chosen period.
  aio_slot_timer #(
    .CNT_W(SLOT_CNT_W),
    .SLOW_CYC(16'(SLOW_SLOT)),
    .FAST_CYC(16'(FAST_SLOT))
  ) u_timer (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .fast(fast),
    .tick(slot_tick)
  );

  // Each tick sends the stored code of the scanned channel and moves on by one.
  // Codes are sent unaltered; straight or offset binary is the converter range's
  // business, so mid-scale 12'h800 is zero volts on a bipolar range.
  always_comb begin
    next_scan = scan;
    next_dac_code = DAC_CODE;
    next_dac_chan = DAC_CHAN;
    if (slot_tick) begin
      next_dac_code = out_code[scan];
      next_dac_chan = scan;
      next_scan = SEL_W'(scan + 1'b1);
    end
  end

  // Register the sequencer and converter outputs.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      scan <= '0;
      DAC_CODE <= CODE_RESET;
      DAC_CHAN <= '0;
      DAC_LOAD <= 1'b0;
    end else begin
      scan <= next_scan;
      DAC_CODE <= next_dac_code;
      DAC_CHAN <= next_dac_chan;
      DAC_LOAD <= slot_tick;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  int unsigned gap;  // Cycles since the last converter load.
  logic seen_load;  // At least one load has happened.
  logic speed_held;  // Speed unchanged since the last load.
  logic [SEL_W-1:0] last_chan;  // Channel of the previous load.

  // Helper state watched only by the checks below.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      gap <= 0;
      seen_load <= 1'b0;
      speed_held <= 1'b1;
      last_chan <= '1;
    end else begin
      gap <= DAC_LOAD ? 0 : gap + 1;
      seen_load <= seen_load | DAC_LOAD;
      speed_held <= DAC_LOAD ? 1'b1 : (speed_held && (next_fast == fast));
      last_chan <= DAC_LOAD ? DAC_CHAN : last_chan;
    end
  end

  chk_sel_write: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ctrl_wr |=> (IN_CHAN_SEL == $past(WDATA[3:0])))
    else $error("input select did not take the low four bits");

  chk_onehot_map: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ##1 (IN_CHAN_ONEHOT == (CHANNELS'(1) << IN_CHAN_SEL)))
    else $error("channel line does not match select code");

  chk_code_readback: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (WR_STB && is_out_addr(ADDR)) ##1 (RD_STB && !WR_STB && (ADDR == $past(ADDR)))
    |=> (RDATA == {4'h0, $past(WDATA[11:0], 2)}))
    else $error("output register read back differs from write");

  chk_top_bits: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    RD_ACK && is_out_addr($past(ADDR)) |-> (RDATA[15:12] == 4'h0))
    else $error("upper bits of an output register were kept");

  chk_slow_slot: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (DAC_LOAD && seen_load && speed_held && !$past(fast)) |-> (gap == SLOW_SLOT - 1))
    else $error("slow refresh slot length wrong");

  chk_fast_slot: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (DAC_LOAD && seen_load && speed_held && $past(fast)) |-> (gap == FAST_SLOT - 1))
    else $error("fast refresh slot length wrong");

  chk_rr_order: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    DAC_LOAD |-> (DAC_CHAN == SEL_W'(last_chan + 1'b1)))
    else $error("refresh skipped or repeated a channel");

  // The code sent is the one stored for the channel scanned in the tick cycle.
  chk_code_pass: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    DAC_LOAD |-> (DAC_CODE == $past(out_code[scan])))
    else $error("converter code differs from stored code");

  chk_online_pin: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ctrl_wr |=> (REAR_IO_CONNECT == $past(WDATA[CTRL_ONLINE_BIT])))
    else $error("rear connector switch does not follow online bit");

  chk_tap_offline: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !REAR_IO_CONNECT |-> SELFTEST_TAP_EN)
    else $error("self-test tap lost while offline");

  // A stored code keeps the low twelve bits of the written word only.
  chk_code_store: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (WR_STB && is_out_addr(ADDR))
    |=> (out_code[out_index($past(ADDR))] == $past(WDATA[11:0])))
    else $error("output register stored the wrong bits");

  // The fast pin follows the control word on the cycle after the write.
  chk_fast_pin: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ctrl_wr |=> (FAST_REFRESH == $past(WDATA[CTRL_FAST_BIT])))
    else $error("fast refresh pin does not follow the control word");

  // No slot outlasts the slow slot, so a sweep never overruns its period.
  chk_gap_bound: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    gap <= SLOW_SLOT)
    else $error("converter load gap exceeds the slow slot");

endmodule

//--- dv/aio_host_model.sv
// Host processor model for the analog I/O channel control block.
// Assumes the one-cycle strobe host port of the block, driven on falling edges.
`timescale 1ns/1ps
module aio_host_model
  import aio_pkg::*;
(
  input wire logic clk,
  output logic [aio_pkg::ADDR_W-1:0] addr,
  output logic wr_stb,
  output logic rd_stb,
  output logic [aio_pkg::WORD_W-1:0] wdata,
  input wire logic [aio_pkg::WORD_W-1:0] rdata,
  input wire logic rd_ack
);
  import aio_pkg::*;
  // ------------------------------------------------------------
  // Idle values
  // ------------------------------------------------------------
  // Bus starts quiet with no strobe raised.
  initial begin
    addr = 8'hff;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  // One write strobe pulse; the qualifiers are inverted after release,
  // so a design that samples them late sees garbage, not the old value.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_stb = 1'b1;
    @(negedge clk);
    wr_stb = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask

  // One read strobe pulse, then a bounded wait for the one-cycle answer.
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output bit ok);
    int i;
    ok = 1'b0;
    d = 16'h0000;
    @(negedge clk);
    addr = a;
    rd_stb = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
    addr = ~a;
    for (i = 0; i < 4 && !ok; i++) begin
      if (rd_ack === 1'b1) begin
        ok = 1'b1;
        d = rdata;
      end else begin
        @(negedge clk);
      end
    end
  endtask

  // Write, then read the same word in the very next cycle with no idle gap;
  // the address stands through both strobes, the answer is taken where it stands.
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q,
                       output bit ok);
    ok = 1'b0;
    q = 16'h0000;
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_stb = 1'b1;
    @(negedge clk);
    wr_stb = 1'b0;
    rd_stb = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
    addr = ~a;
    wdata = ~d;
    ok = (rd_ack === 1'b1);
    q = rdata;
  endtask
endmodule

//--- dv/aio_chan_ctrl_tb.sv
// Self-checking bench for the analog I/O channel control block.
// Assumes short refresh slots so whole sweeps fit in a brief run.
`timescale 1ns/1ps
module aio_chan_ctrl_tb;
  import aio_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int SLOW = 40;  // Shortened slow slot, cycles.
  localparam int FAST = 10;  // Shortened fast slot, cycles.
  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  logic [ADDR_W-1:0] ADDR;
  logic WR_STB, RD_STB, RD_ACK, DAC_LOAD, FAST_REFRESH, REAR_IO_CONNECT, SELFTEST_TAP_EN;
  logic [WORD_W-1:0] WDATA, RDATA;
  logic [SEL_W-1:0] IN_CHAN_SEL, DAC_CHAN;
  logic [CHANNELS-1:0] IN_CHAN_ONEHOT;
  logic [CODE_W-1:0] DAC_CODE;
  int miscompares = 0;
  int n_compared = 0;
  int n_load = 0;  // Converter loads seen so far.
  logic [CODE_W-1:0] exp_code [CHANNELS];  // Expected stored codes.
  logic [CHANNELS-1:0] fresh = '0;  // Channel has shown its newest code.
  logic [SEL_W-1:0] nxt_chan = '0;  // Channel expected at the next load.
  logic [CODE_W-1:0] last_code = '0;  // Code of the latest load.

  always #10 CLK_SYS = ~CLK_SYS;

  aio_chan_ctrl #(.SLOW_SLOT(SLOW), .FAST_SLOT(FAST)) u_aio_chan_ctrl (.CLK_SYS(CLK_SYS),
    .RSTN(RSTN), .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB), .WDATA(WDATA), .RDATA(RDATA),
    .RD_ACK(RD_ACK), .IN_CHAN_SEL(IN_CHAN_SEL), .IN_CHAN_ONEHOT(IN_CHAN_ONEHOT),
    .DAC_CODE(DAC_CODE), .DAC_CHAN(DAC_CHAN), .DAC_LOAD(DAC_LOAD), .FAST_REFRESH(FAST_REFRESH),
    .REAR_IO_CONNECT(REAR_IO_CONNECT), .SELFTEST_TAP_EN(SELFTEST_TAP_EN));
  aio_host_model u_aio_host_model (.clk(CLK_SYS), .addr(ADDR), .wr_stb(WR_STB),
    .rd_stb(RD_STB), .wdata(WDATA), .rdata(RDATA), .rd_ack(RD_ACK));

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  // Verdict and end of run; the only place the run stops.
  task automatic results();
    $display("Compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Case inequality, so an unknown never passes.
  task automatic check(input logic [15:0] got, input logic [15:0] e, input string what);
    n_compared++;
    if (got !== e) begin
      miscompares++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got, e);
    end
  endtask

  // A read that never answers ends the run as a mismatch.
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input string what);
    logic [15:0] r;
    bit ok;
    u_aio_host_model.rd(a, r, ok);
    if (!ok) begin
      check(16'h0000, 16'h0001, "read answer missing");
      results();
    end
    check(r, e, what);
  endtask

  // Control write, then every control output and the read-back.
  task automatic ctrl_wr(input logic [15:0] d);
    u_aio_host_model.wr(OFF_CTRL, d);
    check(16'(IN_CHAN_SEL), 16'(d[3:0]), "input select");
    check(IN_CHAN_ONEHOT, 16'h0001 << d[3:0], "input decode");
    check(16'(REAR_IO_CONNECT), 16'(d[11]), "online switch");
    check(16'(SELFTEST_TAP_EN), 16'h0001, "self-test tap");
    check(16'(FAST_REFRESH), 16'(d[12]), "fast bit");
    rd_chk(OFF_CTRL, d & 16'h180f, "control read-back");
  endtask

  // Fill all output words; corner codes go to the first two channels.
  task automatic fill_codes();
    logic [15:0] d;
    for (int k = 0; k < CHANNELS; k++) begin
      d = 16'($urandom);
      if (k == 0) d = 16'hf800;
      if (k == 1) d = 16'h7fff;
      exp_code[k] = d[11:0];
      fresh[k] = 1'b0;
      u_aio_host_model.wr(8'(OFF_OUT_BASE + 2 * k), d);
    end
  endtask

  // Write one output word and read it back in the next cycle.
  task automatic wr_rd_chk(input int k, input logic [15:0] d);
    logic [15:0] r;
    bit ok;
    exp_code[k] = d[11:0];
    fresh[k] = 1'b0;
    u_aio_host_model.wr_rd(8'(OFF_OUT_BASE + 2 * k), d, r, ok);
    check(16'(ok), 16'h0001, "back-to-back answer");
    check(r, {4'h0, d[11:0]}, "back-to-back read-back");
    if (!ok) results();
  endtask

  // Read all output words back against the expected codes.
  task automatic read_codes();
    for (int k = 0; k < CHANNELS; k++) begin
      rd_chk(8'(OFF_OUT_BASE + 2 * k), {4'h0, exp_code[k]}, "output word");
    end
  endtask

  // Every channel must show its newest code within one sweep.
  task automatic wait_fresh(input int lim);
    for (int i = 0; i < lim && fresh !== '1; i++) @(negedge CLK_SYS);
    check(fresh, 16'hffff, "refresh latency");
    if (fresh !== '1) results();
  endtask

  // ------------------------------------------------------------
  // Converter monitor
  // ------------------------------------------------------------
  // Loads are sampled mid-cycle, where the one-cycle pulse is settled.
  always @(negedge CLK_SYS) begin
    if (RSTN && DAC_LOAD === 1'b1) begin
      check(16'(DAC_CHAN), 16'(nxt_chan), "refresh order");
      if (DAC_CODE === exp_code[DAC_CHAN]) fresh[DAC_CHAN] = 1'b1;
      // The expected converter word comes from the model, not from the pins.
      last_code = exp_code[nxt_chan];
      nxt_chan = DAC_CHAN + 4'h1;
      n_load++;
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int seen;
    for (int k = 0; k < CHANNELS; k++) exp_code[k] = 12'h000;
    void'($urandom(32'h5b2accb6));
    repeat (4) @(negedge CLK_SYS);
    RSTN = 1'b1;
    @(negedge CLK_SYS);
    check(IN_CHAN_ONEHOT, 16'h0001, "reset decode");
    check(16'(REAR_IO_CONNECT), 16'h0000, "reset offline");
    read_codes();
    // Every select code, with random bits above it.
    for (int k = 0; k < CHANNELS; k++) ctrl_wr({16'($urandom)} & 16'hfff0 | 16'(k));
    ctrl_wr(16'h0005);
    fill_codes();
    read_codes();
    wr_rd_chk(5, 16'($urandom));
    wait_fresh(16 * SLOW + 4);
    ctrl_wr(16'h1803);
    fill_codes();
    wait_fresh(16 * FAST + 4);
    // Odd and unmapped places read as zero.
    rd_chk(8'h21, 16'h0000, "odd address");
    rd_chk(OFF_OUT_END, 16'h0000, "past last word");
    // Read-only converter word right after a load, a write to it ignored.
    seen = n_load;
    for (int i = 0; i < FAST + 4 && n_load == seen; i++) @(negedge CLK_SYS);
    check(16'(n_load != seen), 16'h0001, "converter load missing");
    if (n_load == seen) results();
    u_aio_host_model.wr(OFF_CONV_DATA, 16'hffff);
    rd_chk(OFF_CONV_DATA, {4'h0, last_code}, "converter word");
    results();
  end
endmodule
